// ---- hw/pnw_status.sv ----
// partial network wake status register group
`timescale 1ns/1ps
module pnw_status (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic restart,
    input wire logic rd_strobe,
    input wire logic [6:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic frame_ok,
    input wire logic frame_error,
    input wire logic wake_pattern,
    input wire logic wake_frame,
    input wire logic silence_exceeded,
    input wire logic config_valid_flag,
    input wire logic [2:0] transceiver_mode,
    input wire logic mode_write,
    input wire logic mean_valid,
    input wire logic [pnw_pkg::PNW_MEAN_W-1:0] clocks_per_bit_mean,
    output logic system_fault_flag,
    output logic partial_wake_active,
    output logic can_wake_enable,
    output logic wake_request
);
    import pnw_pkg::*;

    // ---------------------------------------------------------------
    // register address decode
    // ---------------------------------------------------------------
    // one compare shared by the clear strobe, the read mux and the checks other than a_reserved_zero
    function automatic logic reg_hit(input logic [6:0] addr, input logic [6:0] ofs);
        return addr == ofs;
    endfunction
    wire sel_status = reg_hit(rd_addr, PNW_OFS_STATUS);
    wire sel_errcnt = reg_hit(rd_addr, PNW_OFS_ERRCNT);
    wire sel_timing = reg_hit(rd_addr, PNW_OFS_TIMING);

    // ---------------------------------------------------------------
    // input synchronisers for the pin-level quiet indication
    // ---------------------------------------------------------------
    logic quiet_meta_reg;
    logic quiet_sync_reg;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            quiet_meta_reg <= 1'b0;
            quiet_sync_reg <= 1'b0;
        end else begin
            quiet_meta_reg <= silence_exceeded;
            quiet_sync_reg <= quiet_meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // error tally
    // ---------------------------------------------------------------
    logic [PNW_TALLY_W-1:0] tally;
    logic overflow_pulse;
    pnw_tally pnw_tally_i (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .soft_reset(soft_reset),
        .frame_error(frame_error),
        .frame_valid(frame_ok),
        .tally(tally),
        .overflow_pulse(overflow_pulse)
    );

    // ---------------------------------------------------------------
    // activation and fault
    // ---------------------------------------------------------------
    logic fault_reg;
    logic fault_next;
    logic armed_reg;
    logic armed_next;
    logic wake_en_reg;
    logic wake_en_next;
    wire mode_ok = transceiver_mode[PNW_MODE_SELECT_BIT];
    wire mode_trigger = mode_write && (transceiver_mode != PNW_MODE_NOACT);
    wire active_now = armed_reg && !fault_reg && config_valid_flag && mode_ok;

    assign fault_next = fault_reg || overflow_pulse;
    // overflow drops the function even if a mode write lands the same cycle
    assign armed_next = overflow_pulse ? 1'b0 :
                        mode_trigger ? 1'b1 : armed_reg;
    assign wake_en_next = wake_en_reg || overflow_pulse;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fault_reg <= 1'b0;
            armed_reg <= 1'b0;
            wake_en_reg <= 1'b0;
        end else if (soft_reset) begin
            fault_reg <= 1'b0;
            armed_reg <= 1'b0;
            wake_en_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            armed_reg <= armed_next;
            wake_en_reg <= wake_en_next;
        end
    end

    assign system_fault_flag = fault_reg;
    assign partial_wake_active = active_now;
    assign can_wake_enable = wake_en_reg;
    // plain wake capability answers the next pattern once selective wake is gone
    assign wake_request = wake_en_reg && wake_pattern;

    // ---------------------------------------------------------------
    // status flags
    // ---------------------------------------------------------------
    logic locked_reg;
    logic locked_next;
    logic pattern_reg;
    logic pattern_next;
    logic frame_reg;
    logic frame_next;
    logic [PNW_MEAN_W-1:0] mean_reg;
    logic [PNW_MEAN_W-1:0] mean_next;
    wire rd_status = rd_strobe && sel_status;

    // lock is lost as soon as the function stops running
    assign locked_next = !active_now ? 1'b0 :
                         (frame_ok && !frame_error) ? 1'b1 : locked_reg;
    // set beats the clearing read so no event is dropped
    assign pattern_next = wake_pattern ? 1'b1 : (rd_status ? 1'b0 : pattern_reg);
    assign frame_next = wake_frame ? 1'b1 : (rd_status ? 1'b0 : frame_reg);
    assign mean_next = mean_valid ? clocks_per_bit_mean : mean_reg;

    // restart is not listed in the reset branch: flags simply hold
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            locked_reg <= PNW_RST_STATUS[PNW_BIT_LOCKED];
            pattern_reg <= PNW_RST_STATUS[PNW_BIT_PATTERN];
            frame_reg <= PNW_RST_STATUS[PNW_BIT_FRAME];
            mean_reg <= PNW_RST_TIMING[15:PNW_MEAN_LSB];
        end else if (soft_reset) begin
            locked_reg <= PNW_RST_STATUS[PNW_BIT_LOCKED];
            pattern_reg <= PNW_RST_STATUS[PNW_BIT_PATTERN];
            frame_reg <= PNW_RST_STATUS[PNW_BIT_FRAME];
            mean_reg <= PNW_RST_TIMING[15:PNW_MEAN_LSB];
        end else begin
            locked_reg <= locked_next;
            pattern_reg <= pattern_next;
            frame_reg <= frame_next;
            mean_reg <= mean_next;
        end
    end

    // ---------------------------------------------------------------
    // read decode; reserved bits are constant zero
    // ---------------------------------------------------------------
    wire [15:0] status_word = {9'h000, locked_reg, pattern_reg, frame_reg,
                               quiet_sync_reg && active_now, active_now, 2'h0};
    wire [15:0] tally_word = {10'h000, tally};
    wire [15:0] timing_word = {mean_reg, 4'h0};
    wire [15:0] rd_mux = sel_status ? status_word :
                         sel_errcnt ? tally_word :
                         sel_timing ? timing_word : 16'h0000;
    logic [15:0] rd_data_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rd_data_reg <= 16'h0000;
        end else if (rd_strobe) begin
            rd_data_reg <= rd_mux;
        end
    end
    assign rd_data = rd_data_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_lock_needs_active: assert property (@(posedge clk_sys) disable iff (!resetn)
        locked_reg |-> $past(active_now))
        else $error("lock set without active function");
    a_pattern_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wake_pattern && !soft_reset) |=> pattern_reg)
        else $error("pattern flag not set");
    a_frame_read_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_status && frame_reg && !wake_frame && !soft_reset) |=> !frame_reg)
        else $error("frame flag not cleared by read");
    a_quiet_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
        status_word[PNW_BIT_QUIET] |-> active_now)
        else $error("quiet flag while inactive");
    a_active_terms: assert property (@(posedge clk_sys) disable iff (!resetn)
        partial_wake_active |-> (!fault_reg && config_valid_flag && mode_ok))
        else $error("active without its conditions");
    a_mode_noact: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!armed_reg && mode_write && transceiver_mode == PNW_MODE_NOACT && !overflow_pulse)
        |=> !armed_reg)
        else $error("code 100 armed the function");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_strobe && rd_addr == PNW_OFS_TIMING) |=> rd_data[3:0] == 4'h0)
        else $error("reserved timing bits nonzero");
    a_overflow_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
        (overflow_pulse && !soft_reset) |=> (fault_reg && !armed_reg && wake_en_reg))
        else $error("overflow did not disable function");
    a_read_preclear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_status && pattern_reg) |=> rd_data[PNW_BIT_PATTERN])
        else $error("read lost pattern flag");

    // ---------------------------------------------------------------
    // checks: lock, flags and read-clear
    // ---------------------------------------------------------------
    a_lock_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
        (active_now && frame_ok && !frame_error && !soft_reset)
        |=> locked_reg)
        else $error("lock not taken on clean frame");
    a_lock_drops: assert property (@(posedge clk_sys) disable iff (!resetn)
        !active_now
        |=> !locked_reg)
        else $error("lock kept while inactive");
    a_error_no_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!locked_reg && frame_error)
        |=> !locked_reg)
        else $error("lock taken on a bad frame");
    a_pattern_read_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_status && pattern_reg && !wake_pattern)
        |=> !pattern_reg)
        else $error("pattern flag not cleared by read");
    a_frame_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wake_frame && !soft_reset)
        |=> frame_reg)
        else $error("frame flag not set");
    a_frame_preclear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_status && frame_reg)
        |=> rd_data[PNW_BIT_FRAME])
        else $error("read lost frame flag");
    a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_status && wake_frame && !soft_reset)
        |=> frame_reg)
        else $error("frame event lost under read");

    // ---------------------------------------------------------------
    // checks: activation, quiet time and overflow
    // ---------------------------------------------------------------
    // the synchroniser needs two cycles after reset before it tracks the pin
    a_quiet_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
        (active_now && $past(resetn, 2))
        |-> status_word[PNW_BIT_QUIET] == $past(silence_exceeded, 2))
        else $error("quiet flag does not follow pin");
    a_mode_arms: assert property (@(posedge clk_sys) disable iff (!resetn)
        (mode_trigger && !overflow_pulse && !soft_reset)
        |=> armed_reg)
        else $error("mode change did not arm the function");
    a_fault_blocks: assert property (@(posedge clk_sys) disable iff (!resetn)
        (overflow_pulse && !soft_reset)
        |=> !partial_wake_active)
        else $error("function active after overflow");
    a_overflow_unlocks: assert property (@(posedge clk_sys) disable iff (!resetn)
        (overflow_pulse && !soft_reset)
        |=> ##1 !locked_reg)
        else $error("lock kept after overflow");
    a_fault_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
        (fault_reg && !soft_reset)
        |=> system_fault_flag)
        else $error("fault flag dropped without reset");
    a_wake_en_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wake_en_reg && !soft_reset)
        |=> can_wake_enable)
        else $error("wake capability dropped without reset");

    // ---------------------------------------------------------------
    // checks: reset, restart and read data
    // ---------------------------------------------------------------
    // restart keeps every field and forces nothing; reserved bits are constant zero anyway
    a_soft_reset_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
        soft_reset
        |=> (!locked_reg && !pattern_reg && !frame_reg && !fault_reg && !armed_reg
             && tally == '0))
        else $error("soft reset left state behind");
    a_timing_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
        soft_reset
        |=> mean_reg == PNW_RST_TIMING[15:PNW_MEAN_LSB])
        else $error("timing mean not reset");
    a_restart_tally: assert property (@(posedge clk_sys) disable iff (!resetn)
        (restart && !soft_reset && !frame_error && !frame_ok)
        |=> tally == $past(tally))
        else $error("restart changed the tally");
    a_restart_mean: assert property (@(posedge clk_sys) disable iff (!resetn)
        (restart && !soft_reset && !mean_valid)
        |=> mean_reg == $past(mean_reg))
        else $error("restart changed the timing mean");
    a_restart_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
        (restart && !soft_reset && !wake_pattern && !wake_frame && !rd_status)
        |=> (pattern_reg == $past(pattern_reg)
             && frame_reg == $past(frame_reg)))
        else $error("restart changed a status flag");
    a_status_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_strobe && sel_status)
        |=> (rd_data[15:7] == 9'h000 && rd_data[1:0] == 2'h0))
        else $error("reserved status bits nonzero");
    a_tally_reserved: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_strobe && sel_errcnt)
        |=> rd_data[15:PNW_TALLY_W] == '0)
        else $error("reserved tally bits nonzero");
    a_tally_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_strobe && sel_errcnt)
        |=> rd_data[PNW_TALLY_W-1:0] == $past(tally))
        else $error("tally read back wrong");
    a_timing_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_strobe && sel_timing)
        |=> rd_data[15:PNW_MEAN_LSB] == $past(mean_reg))
        else $error("timing mean read back wrong");
    a_mean_loads: assert property (@(posedge clk_sys) disable iff (!resetn)
        (mean_valid && !soft_reset)
        |=> mean_reg == $past(clocks_per_bit_mean))
        else $error("timing mean not loaded");
    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (rd_strobe && !sel_status && !sel_errcnt && !sel_timing)
        |=> rd_data == 16'h0000)
        else $error("unmapped read not zero");
    a_data_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
        !rd_strobe
        |=> $stable(rd_data))
        else $error("read data changed without a read");

    // ---------------------------------------------------------------
    // covers
    // ---------------------------------------------------------------
    c_overflow: cover property (@(posedge clk_sys) overflow_pulse);
    c_locked: cover property (@(posedge clk_sys) locked_reg && rd_status);
    c_set_clear_same: cover property (@(posedge clk_sys) rd_status && wake_frame);
    c_restart_hold: cover property (@(posedge clk_sys) restart && pattern_reg);
    c_quiet_read: cover property (@(posedge clk_sys) rd_status && status_word[PNW_BIT_QUIET]);
endmodule

// ---- hw/pnw_pkg.sv ----
// package: offsets, field positions and reset values of the partial wake status registers
package pnw_pkg;
    localparam logic [6:0] PNW_OFS_STATUS = 7'h60;
    localparam logic [6:0] PNW_OFS_ERRCNT = 7'h61;
    localparam logic [6:0] PNW_OFS_TIMING = 7'h63;
    localparam int PNW_BIT_LOCKED = 6;
    localparam int PNW_BIT_PATTERN = 5;
    localparam int PNW_BIT_FRAME = 4;
    localparam int PNW_BIT_QUIET = 3;
    localparam int PNW_BIT_ACTIVE = 2;
    localparam int PNW_MEAN_LSB = 4;
    localparam int PNW_TALLY_W = 6;
    localparam int PNW_MEAN_W = 12;
    localparam logic [15:0] PNW_RST_STATUS = 16'h0000;
    localparam logic [15:0] PNW_RST_ERRCNT = 16'h0000;
    localparam logic [15:0] PNW_RST_TIMING = 16'hA000;
    localparam logic [5:0] PNW_TALLY_OVF = 6'h20;
    localparam logic [2:0] PNW_MODE_NOACT = 3'h4;
    localparam int PNW_MODE_SELECT_BIT = 2;
endpackage

// ---- hw/pnw_tally.sv ----
// frame error tally with overflow detection
`timescale 1ns/1ps
module pnw_tally (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic soft_reset,
    input wire logic frame_error,
    input wire logic frame_valid,
    output logic [pnw_pkg::PNW_TALLY_W-1:0] tally,
    output logic overflow_pulse
);
    import pnw_pkg::*;
    logic [PNW_TALLY_W-1:0] tally_reg;
    logic [PNW_TALLY_W-1:0] tally_next;
    wire at_ovf = (tally_reg == PNW_TALLY_OVF);
    wire do_inc = frame_error && !at_ovf;
    wire do_dec = frame_valid && !frame_error && (tally_reg != '0) && !at_ovf;

    // tally sticks at overflow until a reset; an error wins over a valid frame
    assign tally_next = do_inc ? tally_reg + 6'h01 :
                        do_dec ? tally_reg - 6'h01 : tally_reg;
    assign overflow_pulse = do_inc && (tally_reg == PNW_TALLY_OVF - 6'h01);
    assign tally = tally_reg;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tally_reg <= PNW_RST_ERRCNT[PNW_TALLY_W-1:0];
        end else if (soft_reset) begin
            tally_reg <= PNW_RST_ERRCNT[PNW_TALLY_W-1:0];
        end else begin
            tally_reg <= tally_next;
        end
    end

    a_tally_inc: assert property (@(posedge clk_sys) disable iff (!resetn)
        (frame_error && !at_ovf && !soft_reset)
        |=> tally_reg == $past(tally_reg) + 6'h01)
        else $error("tally did not increment");
    a_tally_dec: assert property (@(posedge clk_sys) disable iff (!resetn)
        (frame_valid && !frame_error && !soft_reset && tally_reg != 6'h00 && !at_ovf)
        |=> tally_reg == $past(tally_reg) - 6'h01)
        else $error("tally did not decrement");
    a_tally_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
        (at_ovf && !soft_reset) |=> at_ovf)
        else $error("tally left overflow");
endmodule

// ---- test/tb_partial_network_wake_status.sv ----
// self-checking bench for the partial wake status register group
`timescale 1ns/1ps
module tb_partial_network_wake_status;
    import pnw_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic rd_strobe = 1'b0;
    logic [6:0] rd_addr = 7'h00;
    logic [15:0] rd_data;
    logic silence_exceeded = 1'b0;
    logic config_valid_flag = 1'b0;
    logic [2:0] transceiver_mode = 3'h0;
    logic [PNW_MEAN_W-1:0] clocks_per_bit_mean = 12'h000;
    logic [7:0] ev = 8'h00;
    logic system_fault_flag, partial_wake_active, can_wake_enable, wake_request;
    int mismatches = 0;
    int compares = 0;

    always #5 clk_sys = ~clk_sys;

    pnw_status pnw_status_i (
        .clk_sys(clk_sys), .resetn(resetn), .soft_reset(ev[7]), .restart(ev[6]),
        .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
        .frame_ok(ev[0]), .frame_error(ev[1]), .wake_pattern(ev[2]), .wake_frame(ev[3]),
        .silence_exceeded(silence_exceeded), .config_valid_flag(config_valid_flag),
        .transceiver_mode(transceiver_mode), .mode_write(ev[4]), .mean_valid(ev[5]),
        .clocks_per_bit_mean(clocks_per_bit_mean), .system_fault_flag(system_fault_flag),
        .partial_wake_active(partial_wake_active), .can_wake_enable(can_wake_enable),
        .wake_request(wake_request)
    );

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // event bits: 0 frame ok, 1 frame error, 2 pattern, 3 frame, 4 mode write,
    // 5 mean load, 6 restart, 7 soft reset; a low cycle separates pulses
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1 ev[sel] = 1'b1;
            @(posedge clk_sys);
            #1 ev[sel] = 1'b0;
        end
    endtask

    // with_pat raises a wake pattern in the very cycle the read is taken
    task automatic rd(input logic [6:0] a, input logic [15:0] exp, input string name,
                      input bit with_pat = 1'b0);
        @(posedge clk_sys);
        #1 rd_strobe = 1'b1;
        rd_addr = a;
        ev[2] = with_pat;
        @(posedge clk_sys);
        #1 rd_strobe = 1'b0;
        ev[2] = 1'b0;
        @(posedge clk_sys);
        #1 chk(name, exp, rd_data);
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        rd(PNW_OFS_STATUS, PNW_RST_STATUS, "status");
        rd(PNW_OFS_ERRCNT, PNW_RST_ERRCNT, "tally");
        rd(PNW_OFS_TIMING, PNW_RST_TIMING, "timing");
        rd(7'h62, 16'h0000, "unmapped");
        $display("test reset done");
        config_valid_flag = 1'b1;
        transceiver_mode = PNW_MODE_NOACT;
        pulse(4, 1);
        rd(PNW_OFS_STATUS, 16'h0000, "status");
        transceiver_mode = 3'h6;
        pulse(4, 1);
        rd(PNW_OFS_STATUS, 16'h0004, "status");
        chk("active", 16'h0001, {15'h0, partial_wake_active});
        config_valid_flag = 1'b0;
        rd(PNW_OFS_STATUS, 16'h0000, "status");
        config_valid_flag = 1'b1;
        pulse(0, 1);
        rd(PNW_OFS_STATUS, 16'h0044, "status");
        $display("test activate done");
        for (int k = 2; k < 4; k++) begin
            pulse(k, 1);
            rd(PNW_OFS_STATUS, 16'h0044 | (16'h0001 << (7 - k)), "status");
            rd(PNW_OFS_STATUS, 16'h0044, "status");
        end
        rd(PNW_OFS_STATUS, 16'h0044, "status", 1'b1);
        rd(PNW_OFS_STATUS, 16'h0064, "status");
        rd(PNW_OFS_STATUS, 16'h0044, "status");
        silence_exceeded = 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(PNW_OFS_STATUS, 16'h004C, "status");
        silence_exceeded = 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(PNW_OFS_STATUS, 16'h0044, "status");
        $display("test flags done");
        pulse(1, 3);
        rd(PNW_OFS_ERRCNT, 16'h0003, "tally");
        pulse(0, 1);
        rd(PNW_OFS_ERRCNT, 16'h0002, "tally");
        pulse(1, 29);
        rd(PNW_OFS_ERRCNT, 16'h001F, "tally");
        chk("fault", 16'h0000, {15'h0, system_fault_flag});
        pulse(1, 1);
        rd(PNW_OFS_ERRCNT, {10'h0, PNW_TALLY_OVF}, "tally");
        chk("fault", 16'h0001, {15'h0, system_fault_flag});
        chk("wake_en", 16'h0001, {15'h0, can_wake_enable});
        rd(PNW_OFS_STATUS, 16'h0000, "status");
        pulse(0, 1);
        rd(PNW_OFS_ERRCNT, 16'h0020, "tally");
        @(posedge clk_sys);
        #1 ev[2] = 1'b1;
        #1 chk("wake_req", 16'h0001, {15'h0, wake_request});
        @(posedge clk_sys);
        #1 ev[2] = 1'b0;
        $display("test tally done");
        clocks_per_bit_mean = 12'hABC;
        pulse(5, 1);
        rd(PNW_OFS_TIMING, 16'hABC0, "timing");
        pulse(6, 1);
        rd(PNW_OFS_TIMING, 16'hABC0, "timing");
        rd(PNW_OFS_ERRCNT, 16'h0020, "tally");
        rd(PNW_OFS_STATUS, 16'h0020, "status");
        pulse(7, 1);
        rd(PNW_OFS_STATUS, PNW_RST_STATUS, "status");
        rd(PNW_OFS_ERRCNT, PNW_RST_ERRCNT, "tally");
        rd(PNW_OFS_TIMING, PNW_RST_TIMING, "timing");
        chk("fault", 16'h0000, {15'h0, system_fault_flag});
        $display("test timing done");
        give_verdict();
    end
endmodule
